/* File: rtl/rcp_pin_logic.sv */
// Purpose: control inputs, sleep requests, status outputs, interrupt pin
// Assumes: pins synchronous to aclk; open-drain pads resolved outside
// Notes: regulator power-good comes in per regulator on vr_pgood
`timescale 1ns/1ns
module rcp_pin_logic (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [rcp_pkg::NUM_CTL-1:0] rail_group_enable_in,
    input wire logic [rcp_pkg::NUM_VR-1:0] vr_pgood,
    output logic [rcp_pkg::NUM_VR-1:0] vr_enable,
    output logic [rcp_pkg::NUM_VR-1:0] vr_sleep,
    output logic [rcp_pkg::NUM_VR*8-1:0] vr_vsel,
    output logic [rcp_pkg::NUM_GPO-1:0] status_out_o,
    output logic [rcp_pkg::NUM_GPO-1:0] status_out_oe,
    output logic interrupt_out_n_o,
    output logic interrupt_out_n_oe,
    output logic interrupt_level,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import rcp_pkg::*;

    typedef struct packed {
        logic [NUM_CTL-1:0][NUM_VR-1:0] ctl_map;
        logic [1:0] slp_mode;
        logic [NUM_VR-1:0] slp_map_a;
        logic [NUM_VR-1:0] slp_map_b;
        logic [11:0] gpo_cfg;
        logic [NUM_GPO-1:0][NUM_VR-1:0] gpo_pg;
        logic [NUM_VR-1:0][7:0] vsel_norm;
        logic [NUM_VR-1:0][7:0] vsel_slp;
        logic [NUM_IRQ-1:0] irq_stat;
        logic [NUM_IRQ-1:0] irq_mask;
        logic [NUM_CTL-1:0] ctl_prev;
        logic [NUM_VR-1:0] pg_prev;
        logic [NUM_VR-1:0] en;
        logic [NUM_VR-1:0] slp;
        logic [NUM_GPO-1:0] gpo_lvl;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rcp_state_type;

    rcp_state_type st_q;
    rcp_state_type st_d;

    function automatic logic [31:0] rcp_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : rcp_merge

    logic [7:0] ra;
    logic [7:0] wa;
    logic [31:0] rd;
    logic rd_ok;
    logic wr_ok;
    logic [31:0] wv;
    logic [NUM_VR-1:0] sleep_now;
    logic pg_rise_any;
    logic pg_fall_any;
    logic ctl_rise_any;
    logic ctl_fall_any;
    logic [NUM_IRQ-1:0] irq_set;
    logic [NUM_IRQ-1:0] irq_clr;

    always_comb begin
        st_d = st_q;
        ra = s_axi_araddr[7:0];
        wa = st_q.aw_addr;
        rd = RST_WORD;
        rd_ok = 1'b1;
        wr_ok = 1'b1;
        wv = RST_WORD;
        sleep_now = '0;
        irq_set = '0;
        irq_clr = '0;

        // enable is OR of every non-sleep input whose group holds the rail
        st_d.en = '0;
        for (int c = 0; c < NUM_CTL; c++) begin
            if (c == 2 && st_q.slp_mode[SLP_MODE_A_POS]) begin
                if (!rail_group_enable_in[c]) begin
                    sleep_now = sleep_now | st_q.slp_map_a;
                end
            end else if (c == 5 && st_q.slp_mode[SLP_MODE_B_POS]) begin
                if (!rail_group_enable_in[c]) begin
                    sleep_now = sleep_now | st_q.slp_map_b;
                end
            end else if (rail_group_enable_in[c]) begin
                st_d.en = st_d.en | st_q.ctl_map[c];
            end
        end
        st_d.slp = sleep_now;
        st_d.ctl_prev = rail_group_enable_in;
        st_d.pg_prev = vr_pgood;

        // empty power-good selection reads as not good, not vacuously true
        for (int g = 0; g < NUM_GPO; g++) begin
            if (st_q.gpo_cfg[GPO_CFG_SRC_POS + g]) begin
                st_d.gpo_lvl[g] = st_q.gpo_cfg[GPO_CFG_BIT_POS + g];
            end else begin
                st_d.gpo_lvl[g] = (st_q.gpo_pg[g] != '0) &&
                    ((vr_pgood & st_q.gpo_pg[g]) == st_q.gpo_pg[g]);
            end
        end

        irq_set[IRQ_PG_RISE_POS] = pg_rise_any;
        irq_set[IRQ_PG_FALL_POS] = pg_fall_any;
        irq_set[IRQ_CTL_POS] = ctl_rise_any || ctl_fall_any;

        // read channel: address taken when no answer is outstanding
        if (s_axi_arvalid && !st_q.rvalid) begin
            if (ra[7] && ra[1:0] == 2'h0) begin
                for (int v = 0; v < NUM_VR; v++) begin
                    if (ra[6:2] == 5'(v)) begin
                        rd = {16'h0000, st_q.vsel_slp[v], st_q.vsel_norm[v]};
                    end
                end
                rd_ok = ra[6:2] < 5'(NUM_VR);
            end else if (ra < OFS_SLP_MODE && ra[1:0] == 2'h0) begin
                rd = {16'h0000, st_q.ctl_map[ra[4:2]]};
            end else if (ra >= OFS_GPO_PG_0 && ra < OFS_VR_STATE &&
                         ra[1:0] == 2'h0) begin
                rd = {16'h0000, st_q.gpo_pg[2'(ra[5:2] - 4'hA)]};
            end else begin
                case (ra)
                    OFS_SLP_MODE: rd = {30'h0, st_q.slp_mode};
                    OFS_SLP_MAP_A: rd = {16'h0000, st_q.slp_map_a};
                    OFS_SLP_MAP_B: rd = {16'h0000, st_q.slp_map_b};
                    OFS_GPO_CFG: rd = {20'h00000, st_q.gpo_cfg};
                    OFS_VR_STATE: rd = {st_q.slp, st_q.en};
                    OFS_IRQ_STAT: rd = {24'h000000, st_q.irq_stat};
                    OFS_IRQ_MASK: rd = {24'h000000, st_q.irq_mask};
                    OFS_PIN_STATE: rd = {22'h0, st_q.gpo_lvl,
                                         rail_group_enable_in};
                    default: rd_ok = 1'b0;
                endcase
            end
            st_d.rvalid = 1'b1;
            st_d.rdata = rd_ok ? rd : RST_WORD;
            st_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end

        // write channel: address and data latched independently
        if (s_axi_awvalid && !st_q.aw_hold) begin
            st_d.aw_hold = 1'b1;
            st_d.aw_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !st_q.w_hold) begin
            st_d.w_hold = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.aw_hold && st_q.w_hold && !st_q.bvalid) begin
            st_d.aw_hold = 1'b0;
            st_d.w_hold = 1'b0;
            st_d.bvalid = 1'b1;
            if (wa[7] && wa[1:0] == 2'h0 && wa[6:2] < 5'(NUM_VR)) begin
                for (int v = 0; v < NUM_VR; v++) begin
                    if (wa[6:2] == 5'(v)) begin
                        wv = rcp_merge({16'h0000, st_q.vsel_slp[v],
                                        st_q.vsel_norm[v]},
                                       st_q.w_data, st_q.w_strb);
                        st_d.vsel_norm[v] = wv[7:0];
                        st_d.vsel_slp[v] = wv[15:8];
                    end
                end
            end else if (wa < OFS_SLP_MODE && wa[1:0] == 2'h0) begin
                wv = rcp_merge(RST_WORD, st_q.w_data, st_q.w_strb);
                st_d.ctl_map[wa[4:2]] = wv[NUM_VR-1:0];
            end else if (wa >= OFS_GPO_PG_0 && wa < OFS_VR_STATE &&
                         wa[1:0] == 2'h0) begin
                wv = rcp_merge(RST_WORD, st_q.w_data, st_q.w_strb);
                st_d.gpo_pg[2'(wa[5:2] - 4'hA)] = wv[NUM_VR-1:0];
            end else begin
                wv = rcp_merge(RST_WORD, st_q.w_data, st_q.w_strb);
                case (wa)
                    OFS_SLP_MODE: st_d.slp_mode = wv[1:0];
                    OFS_SLP_MAP_A: st_d.slp_map_a = wv[NUM_VR-1:0];
                    OFS_SLP_MAP_B: st_d.slp_map_b = wv[NUM_VR-1:0];
                    OFS_GPO_CFG: st_d.gpo_cfg = wv[11:0];
                    OFS_IRQ_STAT: irq_clr = wv[NUM_IRQ-1:0];
                    OFS_IRQ_MASK: st_d.irq_mask = wv[NUM_IRQ-1:0];
                    default: wr_ok = 1'b0;
                endcase
            end
            st_d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end

        // a fresh event wins over a write-one clear in the same cycle
        st_d.irq_stat = (st_q.irq_stat & ~irq_clr) | irq_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign vr_enable = st_q.en;
    assign vr_sleep = st_q.slp;
    for (genvar v = 0; v < NUM_VR; v++) begin : gen_code
        rcp_code_mux u_mux (
            .asleep(st_q.slp[v]),
            .normal_code(st_q.vsel_norm[v]),
            .sleep_code(st_q.vsel_slp[v]),
            .active_code(vr_vsel[v*8 +: 8])
        );
    end

    // power-good is taken as low out of reset: a rail already good there
    // raises one rise event on the first running edge
    rcp_change_detect #(.WIDTH(NUM_VR)) u_pg_edge (
        .now_val(vr_pgood),
        .prev_val(st_q.pg_prev),
        .rise_any(pg_rise_any),
        .fall_any(pg_fall_any)
    );
    rcp_change_detect #(.WIDTH(NUM_CTL)) u_ctl_edge (
        .now_val(rail_group_enable_in),
        .prev_val(st_q.ctl_prev),
        .rise_any(ctl_rise_any),
        .fall_any(ctl_fall_any)
    );

    // pads only ever pull low or drive; the board supplies the pull-ups
    for (genvar g = 0; g < NUM_GPO; g++) begin : gen_status_pad
        if (g < 3) begin : gen_cfg
            rcp_pad_drive #(.CAN_PUSH(1'b1)) u_pad (
                .level(st_q.gpo_lvl[g]),
                .push_pull(st_q.gpo_cfg[GPO_CFG_PP_POS + g]),
                .pad_o(status_out_o[g]),
                .pad_oe(status_out_oe[g])
            );
        end else begin : gen_fixed
            rcp_pad_drive #(.CAN_PUSH(1'b0)) u_pad (
                .level(st_q.gpo_lvl[g]),
                .push_pull(1'b0),
                .pad_o(status_out_o[g]),
                .pad_oe(status_out_oe[g])
            );
        end
    end

    assign interrupt_level = |(st_q.irq_stat & st_q.irq_mask);
    assign interrupt_out_n_o = 1'b0;
    assign interrupt_out_n_oe = interrupt_level;

    // a frozen slave shows no ready, or a beat taken then would be lost;
    // answers still stand while frozen, so hold bready and rready low then
    assign s_axi_awready = !st_q.aw_hold && clk_en;
    assign s_axi_wready = !st_q.w_hold && clk_en;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid && clk_en;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
endmodule : rcp_pin_logic

// one status pad: open-drain pulls low only, push-pull always drives
module rcp_pad_drive #(
    parameter bit CAN_PUSH = 1'b1
) (
    input wire logic level,
    input wire logic push_pull,
    output logic pad_o,
    output logic pad_oe
);
    // a fixed open-drain pad ignores any push-pull request
    assign pad_o = level;
    assign pad_oe = (CAN_PUSH && push_pull) ? 1'b1 : !level;
endmodule : rcp_pad_drive

// active voltage code of one regulator
module rcp_code_mux (
    input wire logic asleep,
    input wire logic [7:0] normal_code,
    input wire logic [7:0] sleep_code,
    output logic [7:0] active_code
);
    assign active_code = asleep ? sleep_code : normal_code;
endmodule : rcp_code_mux

// compares a sampled word with its previous sample
module rcp_change_detect #(
    parameter int WIDTH = 1
) (
    input wire logic [WIDTH-1:0] now_val,
    input wire logic [WIDTH-1:0] prev_val,
    output logic rise_any,
    output logic fall_any
);
    assign rise_any = |(now_val & ~prev_val);
    assign fall_any = |(~now_val & prev_val);
endmodule : rcp_change_detect

/* File: rtl/rcp_pkg.sv */
// Purpose: shared constants for the rail control pin logic
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: regulator count and interrupt layout are parameters of this build
package rcp_pkg;
    localparam int NUM_VR = 16;
    localparam int NUM_CTL = 6;
    localparam int NUM_GPO = 4;
    localparam int NUM_IRQ = 8;
    localparam logic [7:0] OFS_CTL_MAP_0 = 8'h00;
    localparam logic [7:0] OFS_SLP_MODE = 8'h18;
    localparam logic [7:0] OFS_SLP_MAP_A = 8'h1C;
    localparam logic [7:0] OFS_SLP_MAP_B = 8'h20;
    localparam logic [7:0] OFS_GPO_CFG = 8'h24;
    localparam logic [7:0] OFS_GPO_PG_0 = 8'h28;
    localparam logic [7:0] OFS_VR_STATE = 8'h38;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h3C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h40;
    localparam logic [7:0] OFS_PIN_STATE = 8'h44;
    localparam logic [7:0] OFS_VSEL_0 = 8'h80;
    localparam int GPO_CFG_SRC_POS = 0;
    localparam int GPO_CFG_PP_POS = 4;
    localparam int GPO_CFG_BIT_POS = 8;
    localparam int SLP_MODE_A_POS = 0;
    localparam int SLP_MODE_B_POS = 1;
    localparam int IRQ_PG_RISE_POS = 0;
    localparam int IRQ_PG_FALL_POS = 1;
    localparam int IRQ_CTL_POS = 2;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rcp_pkg

/* File: verif/rcp_host_model.sv */
// Purpose: host side of the control and status pins
// Assumes: host launches pin changes on aclk edges
// Notes: every status pin and the interrupt line has a pull-up
`timescale 1ns/1ns
module rcp_host_model (
    input wire logic aclk,
    input wire logic [rcp_pkg::NUM_CTL-1:0] want,
    output logic [rcp_pkg::NUM_CTL-1:0] rail_group_enable_in,
    input wire logic [rcp_pkg::NUM_GPO-1:0] status_out_o,
    input wire logic [rcp_pkg::NUM_GPO-1:0] status_out_oe,
    input wire logic interrupt_out_n_o,
    input wire logic interrupt_out_n_oe,
    output logic [rcp_pkg::NUM_GPO-1:0] status_pin,
    output logic interrupt_pin_n
);
    import rcp_pkg::*;
    always @(posedge aclk) rail_group_enable_in <= want;
    // released pins read the pull-up level, never the last driven value
    assign status_pin = (status_out_oe & status_out_o) | ~status_out_oe;
    assign interrupt_pin_n = interrupt_out_n_oe ? interrupt_out_n_o : 1'b1;
endmodule : rcp_host_model

/* File: verif/rcp_pin_logic_tb.sv */
// Purpose: self-checking bench for the rail control pin logic
// Assumes: clk_en dropped only with the bus idle, all byte strobes set
// Notes: pin changes take two edges through host model and design; pins waits three
`timescale 1ns/1ns
module rcp_pin_logic_tb;
    import rcp_pkg::*;
    logic aclk = 0;
    logic aresetn = 0;
    logic clk_en = 1;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [31:0] s_axi_rdata, q;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, b;
    logic [NUM_CTL-1:0] want = 0, rail_group_enable_in;
    logic [NUM_VR-1:0] vr_pgood = 0, vr_enable, vr_sleep;
    logic [NUM_VR*8-1:0] vr_vsel;
    logic [NUM_GPO-1:0] status_out_o, status_out_oe, status_pin;
    logic interrupt_out_n_o, interrupt_out_n_oe, interrupt_level;
    logic interrupt_pin_n;
    int err_total = 0, samples_checked = 0;
    always #4 aclk = ~aclk;
    rcp_pin_logic dut (.aclk, .aresetn, .clk_en, .rail_group_enable_in,
        .vr_pgood, .vr_enable, .vr_sleep, .vr_vsel, .status_out_o,
        .status_out_oe, .interrupt_out_n_o, .interrupt_out_n_oe,
        .interrupt_level, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    rcp_host_model host (.aclk, .want, .rail_group_enable_in, .status_out_o,
        .status_out_oe, .interrupt_out_n_o, .interrupt_out_n_oe,
        .status_pin, .interrupt_pin_n);
    task automatic stop_test();
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic bad(input string m);
        err_total++;
        $display("BAD %0t %s", $time, m);
    endtask : bad
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        samples_checked++;
        if (g !== e) bad(m);
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit done = 0;
        @(posedge aclk);
        s_axi_awaddr <= {24'h00, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin
                done = 1;
                b = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end else if (n > 1) s_axi_bready <= 1'b1;
        end
        if (!done) begin
            bad("write hangs");
            stop_test();
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] rs);
        bit done = 0;
        @(posedge aclk);
        s_axi_araddr <= {24'h00, a};
        s_axi_arvalid <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rready && s_axi_rvalid) begin
                done = 1;
                d = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end else if (n > 0) s_axi_rready <= 1'b1;
        end
        if (!done) begin
            bad("read hangs");
            stop_test();
        end
    endtask : rd
    // host model adds one edge, the design one more
    task automatic pins(input logic [NUM_CTL-1:0] v);
        want <= v;
        repeat (3) @(posedge aclk);
    endtask : pins
    task automatic t_enable();
        rd(OFS_VR_STATE, q, r);
        chk(q, 32'h0, "rails at reset");
        chk(status_out_oe, 4'hF, "od at reset");
        for (int i = 0; i < NUM_CTL; i++) wr(8'(4 * i), 32'(1 << i));
        for (int i = 0; i < NUM_CTL; i++) begin
            pins(6'(1 << i));
            chk(vr_enable, 32'(1 << i), "group on");
        end
        pins(6'h00);
        chk(vr_enable, 32'h0, "group off");
        chk(interrupt_pin_n, 1'b1, "masked irq");
    endtask : t_enable
    task automatic t_sleep();
        for (int k = 0; k < 2; k++) begin
            int g = k ? 5 : 2;
            wr(OFS_VSEL_0 + 8'(4 * g), 32'h0000_2211);
            wr(OFS_CTL_MAP_0, 32'(1 << g));
            wr(OFS_SLP_MODE, 32'(1 << k));
            wr(k ? OFS_SLP_MAP_B : OFS_SLP_MAP_A, 32'(1 << g));
            pins(6'(1 | (1 << g)));
            chk(vr_sleep, 32'h0, "awake");
            chk(vr_vsel[g*8 +: 8], 8'h11, "normal code");
            pins(6'h01);
            chk(vr_sleep, 32'(1 << g), "asleep");
            chk(vr_vsel[g*8 +: 8], 8'h22, "sleep code");
            chk(vr_enable[g], 1'b1, "rail kept");
            pins(6'(1 | (1 << g)));
            chk(vr_sleep, 32'h0, "woken");
        end
        wr(OFS_SLP_MODE, 32'h0);
    endtask : t_sleep
    task automatic t_outputs();
        vr_pgood <= 16'h0007;
        wr(OFS_GPO_PG_0, 32'h3);
        wr(OFS_GPO_PG_0 + 8'h04, 32'h4);
        wr(OFS_GPO_CFG, 32'h0000_0828);
        pins(6'h00);
        chk(status_out_o, 4'hB, "levels");
        chk(status_out_oe, 4'h6, "drivers");
        chk(status_pin, 4'hB, "pins");
        vr_pgood <= 16'h0001;
        wr(OFS_GPO_CFG, 32'h0000_0028);
        pins(6'h00);
        chk(status_out_o, 4'h0, "levels low");
        chk(status_out_oe, 4'hF, "pulled low");
        chk(status_pin, 4'h0, "pins low");
    endtask : t_outputs
    task automatic t_irq();
        wr(OFS_IRQ_STAT, 32'h7);
        wr(OFS_IRQ_MASK, 32'(1 << IRQ_CTL_POS));
        chk(b, RESP_OKAY, "write okay");
        pins(6'h02);
        chk(interrupt_pin_n, 1'b0, "irq low");
        rd(OFS_IRQ_STAT, q, r);
        chk(q[IRQ_CTL_POS], 1'b1, "event kept");
        chk(r, RESP_OKAY, "read okay");
        wr(OFS_IRQ_STAT, 32'(1 << IRQ_CTL_POS));
        pins(6'h02);
        chk(interrupt_pin_n, 1'b1, "irq released");
        rd(8'h60, q, r);
        chk(r, RESP_SLVERR, "unmapped resp");
        chk(q, 32'h0, "unmapped data");
        wr(8'h60, 32'h1);
        chk(b, RESP_SLVERR, "unmapped write");
    endtask : t_irq
    // input 1 maps rail 1, input 0 maps rail 5 as written before
    task automatic t_freeze();
        clk_en <= 1'b0;
        pins(6'h01);
        chk(vr_enable, 32'h0000_0002, "frozen");
        chk(s_axi_awready, 1'b0, "bus frozen");
        clk_en <= 1'b1;
        pins(6'h01);
        chk(vr_enable, 32'h0000_0020, "thawed");
    endtask : t_freeze
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_enable();
        t_sleep();
        t_outputs();
        t_irq();
        t_freeze();
        stop_test();
    end
endmodule : rcp_pin_logic_tb

/* File: verif/rcp_pin_monitor.sv */
// Purpose: port checker for the rail control pin logic
// Assumes: clk_en dropped only while the bus is idle
// Notes: bound to every rcp_pin_logic instance
`timescale 1ns/1ns
module rcp_pin_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic s_axi_awready,
    input wire logic [rcp_pkg::NUM_GPO-1:0] status_out_o,
    input wire logic [rcp_pkg::NUM_GPO-1:0] status_out_oe,
    input wire logic interrupt_out_n_o,
    input wire logic interrupt_out_n_oe,
    input wire logic interrupt_level,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    import rcp_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    irq_pin_low_a: assert property (!interrupt_out_n_o)
        else $error("interrupt pin driven high");
    irq_follow_a: assert property (
        interrupt_out_n_oe == interrupt_level) else $error("irq pin wrong");
    out4_od_a: assert property (
        status_out_oe[3] == !status_out_o[3]) else $error("out4 not od");
    od_no_float_a: assert property (
        &(status_out_oe[2:0] | status_out_o[2:0])) else $error("low floats");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read not answered");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("write answer dropped");
    frozen_ready_a: assert property (!clk_en |-> !s_axi_awready &&
        !s_axi_arready) else $error("bus ready while frozen");
    cover property (interrupt_out_n_oe);
    cover property (!clk_en);
    cover property (status_out_oe[1] && !status_out_o[1]);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule : rcp_pin_monitor
bind rcp_pin_logic rcp_pin_monitor mon (.aclk, .aresetn, .clk_en,
    .s_axi_awready, .status_out_o,
    .status_out_oe, .interrupt_out_n_o, .interrupt_out_n_oe,
    .interrupt_level, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready);
